// file: dsc_regs.sv
`timescale 1ns/1ps
module dsc_regs #(
    parameter int AW = 8,
    parameter int DW = 16,
    parameter logic [5:0] PART_ID = 6'h2a,   // arbitrary value
    parameter logic [1:0] REV_ID = 2'h0      // arbitrary value
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // Register access from the serial interface
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Sequencer and memory status
    input wire logic [3:0] run_set_in,
    input wire logic factory_load_check_fail_in,
    input wire logic user_load_check_fail_in,
    input wire logic nonvolatile_busy_in,
    input wire logic soft_reset_in,
    // Control outputs
    output logic [3:0] channel_run_out,
    output logic sequencer_active_out,
    output logic sequencer_abort_out,
    output logic quick_readback_enable_out,
    output logic readback_output_enable_out,
    output logic bus_timeout_enable_out
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0] run;
        logic factory_fail;
        logic user_fail;
        logic busy;
        logic timeout_en;
        logic quick_en;
        logic readback_en;
        logic [2:0] seq;
        logic [AW-1:0] ptr;
        logic word_rd_pend;
        logic active;
        logic [15:0] rdata;
        logic rvalid;
    } dsc_state_t;

    dsc_state_t state_reg;
    dsc_state_t state_next;

    // ****************************************
    // Parameter memory
    // ****************************************
    dsc_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

    dsc_param_mem #(.AW(AW), .DW(DW)) u_mem (
        .mclk_in(mclk_in),
        .port(mem_bus.mem)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    function automatic logic [15:0] run_word(input logic [3:0] r);
        logic [15:0] w;
        w = dsc_pkg::ZERO16;
        for (int i = 0; i < dsc_pkg::NUM_CH; i++) begin
            w[i*dsc_pkg::RUN_STRIDE] = r[i];
        end
        run_word = w;
    endfunction

    logic wr_word;
    logic rd_word;
    assign wr_word = reg_wr_in && hit(reg_addr_in, dsc_pkg::WORD_ADDR);
    assign rd_word = reg_rd_in && hit(reg_addr_in, dsc_pkg::WORD_ADDR);
    assign mem_bus.we = wr_word;
    assign mem_bus.addr = state_reg.ptr;
    assign mem_bus.wdata = reg_wdata_in;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [15:0] rd;
        rd = dsc_pkg::ZERO16;
        state_next = state_reg;
        // Strobes last one cycle unless raised below
        state_next.rvalid = 1'b0;
        state_next.word_rd_pend = 1'b0;
        state_next.busy = nonvolatile_busy_in;

        if (reg_wr_in && hit(reg_addr_in, dsc_pkg::RUN_CTRL_ADDR)) begin
            for (int i = 0; i < dsc_pkg::NUM_CH; i++) begin
                if (!reg_wdata_in[i*dsc_pkg::RUN_STRIDE]) begin
                    state_next.run[i] = 1'b0;
                end
            end
        end
        state_next.run = state_next.run | run_set_in;

        // sticky, set wins over soft reset
        if (soft_reset_in) begin
            state_next.factory_fail = 1'b0;
            state_next.user_fail = 1'b0;
        end
        if (factory_load_check_fail_in) begin
            state_next.factory_fail = 1'b1;
        end
        if (user_load_check_fail_in) begin
            state_next.user_fail = 1'b1;
        end

        if (reg_wr_in && hit(reg_addr_in, dsc_pkg::IFACE_ADDR)) begin
            state_next.timeout_en = reg_wdata_in[dsc_pkg::IF_TIMEOUT_BIT];
            state_next.readback_en = reg_wdata_in[dsc_pkg::IF_READBACK_BIT];
            state_next.quick_en = reg_wdata_in[dsc_pkg::IF_QUICK_BIT];
        end

        if (reg_wr_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR)) begin
            state_next.seq = reg_wdata_in[2:0];
        end
        // start gated by enable; kept in a flop so the output has no logic behind it
        state_next.active = state_next.seq[dsc_pkg::SEQ_RUN_BIT] && state_next.seq[dsc_pkg::SEQ_EN_BIT]
                            && !state_next.seq[dsc_pkg::SEQ_ABORT_BIT];

        if (reg_wr_in && hit(reg_addr_in, dsc_pkg::PTR_ADDR)) begin
            state_next.ptr = reg_wdata_in[AW-1:0];
        end
        // auto increment
        // Wraps at the top of the pointer range, so long bursts roll over to zero
        if (wr_word) begin
            state_next.ptr = state_reg.ptr + AW'(dsc_pkg::PTR_STEP);
        end

        if (reg_rd_in) begin
            unique case (reg_addr_in)
                dsc_pkg::RUN_CTRL_ADDR: rd = run_word(state_reg.run);
                dsc_pkg::STATUS_ADDR: begin
                    rd[dsc_pkg::ST_FACTORY_BIT] = state_reg.factory_fail;
                    rd[dsc_pkg::ST_USER_BIT] = state_reg.user_fail;
                    rd[dsc_pkg::ST_BUSY_BIT] = state_reg.busy;
                    rd[dsc_pkg::ST_PART_LSB +: dsc_pkg::ST_PART_W] = PART_ID;
                    rd[dsc_pkg::ST_REV_W-1:0] = REV_ID;
                end
                dsc_pkg::IFACE_ADDR: begin
                    rd[dsc_pkg::IF_TIMEOUT_BIT] = state_reg.timeout_en;
                    rd[dsc_pkg::IF_QUICK_BIT] = state_reg.quick_en;
                    rd[dsc_pkg::IF_READBACK_BIT] = state_reg.readback_en;
                end
                dsc_pkg::SEQ_CTRL_ADDR: rd[2:0] = state_reg.seq;
                dsc_pkg::PTR_ADDR: rd[AW-1:0] = state_reg.ptr;
                default: rd = dsc_pkg::ZERO16;
            endcase
            // Word reads answer one cycle later than the rest
            if (rd_word) begin
                state_next.word_rd_pend = 1'b1;
            end else begin
                state_next.rdata = rd;
                state_next.rvalid = 1'b1;
            end
        end
        // Memory read data arrive one cycle late
        if (state_reg.word_rd_pend) begin
            state_next.rdata = mem_bus.rdata;
            state_next.rvalid = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
            state_reg.seq <= dsc_pkg::SEQ_CTRL_RST;
            state_reg.ptr <= AW'(dsc_pkg::PTR_RST);
            state_reg.active <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_out = state_reg.rdata;
    assign reg_rvalid_out = state_reg.rvalid;
    assign channel_run_out = state_reg.run;
    assign sequencer_active_out = state_reg.active;
    assign sequencer_abort_out = state_reg.seq[dsc_pkg::SEQ_ABORT_BIT];
    assign quick_readback_enable_out = state_reg.quick_en;
    assign readback_output_enable_out = state_reg.readback_en;
    assign bus_timeout_enable_out = state_reg.timeout_en;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    run_stop_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::RUN_CTRL_ADDR) && !reg_wdata_in[0] && !run_set_in[0]
        |=> !channel_run_out[0]) else $error("run bit not stopped");
    run_set_a: assert property (
        run_set_in[3] |=> channel_run_out[3]) else $error("run bit not set");
    factory_fail_a: assert property (
        factory_load_check_fail_in |=> state_reg.factory_fail) else $error("factory flag lost");
    user_fail_a: assert property (
        user_load_check_fail_in ##1 !soft_reset_in[*2] |=> state_reg.user_fail) else $error("user flag lost");
    busy_track_a: assert property (
        nonvolatile_busy_in |=> state_reg.busy) else $error("busy not shown");
    quick_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::IFACE_ADDR)
        |=> quick_readback_enable_out == $past(reg_wdata_in[2])) else $error("quick bit wrong");
    abort_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR) && reg_wdata_in[2]
        |=> sequencer_abort_out && !sequencer_active_out) else $error("abort ignored");
    start_disable_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR) && !reg_wdata_in[dsc_pkg::SEQ_EN_BIT]
        |=> !sequencer_active_out) else $error("start without enable");
    ptr_incr_a: assert property (
        wr_word |=> state_reg.ptr == $past(state_reg.ptr) + AW'(dsc_pkg::PTR_STEP)) else $error("pointer stuck");
    word_read_a: assert property (
        rd_word |-> ##2 reg_rvalid_out) else $error("word read missing");

    // ****************************************
    // Per-channel and field checks
    // ****************************************
    // host can only stop a channel
    for (genvar ch = 0; ch < dsc_pkg::NUM_CH; ch++) begin : g_chan_chk
        chan_stop_a: assert property (
            reg_wr_in && hit(reg_addr_in, dsc_pkg::RUN_CTRL_ADDR) && !reg_wdata_in[ch*dsc_pkg::RUN_STRIDE]
            && !run_set_in[ch] |=> !channel_run_out[ch]) else $error("channel not stopped");
        chan_no_set_a: assert property (
            !run_set_in[ch] && !channel_run_out[ch] |=> !channel_run_out[ch]) else $error("channel set by host");
    end

    factory_clear_a: assert property (
        soft_reset_in && !factory_load_check_fail_in |=> !state_reg.factory_fail) else $error("factory flag kept");
    user_clear_a: assert property (
        soft_reset_in && !user_load_check_fail_in |=> !state_reg.user_fail) else $error("user flag kept");
    busy_clear_a: assert property (
        !nonvolatile_busy_in |=> !state_reg.busy) else $error("busy stuck");
    status_read_a: assert property (
        reg_rd_in && hit(reg_addr_in, dsc_pkg::STATUS_ADDR) |=> reg_rdata_out[dsc_pkg::ST_FACTORY_BIT] ==
        $past(state_reg.factory_fail) && reg_rdata_out[dsc_pkg::ST_USER_BIT] == $past(state_reg.user_fail)
        && reg_rdata_out[dsc_pkg::ST_BUSY_BIT] == $past(state_reg.busy)) else $error("status read wrong");
    iface_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::IFACE_ADDR)
        |=> bus_timeout_enable_out == $past(reg_wdata_in[dsc_pkg::IF_TIMEOUT_BIT])
        && readback_output_enable_out == $past(reg_wdata_in[dsc_pkg::IF_READBACK_BIT])) else $error("iface bits wrong");
    // abort clears on write of zero
    abort_clear_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR) && !reg_wdata_in[dsc_pkg::SEQ_ABORT_BIT]
        |=> !sequencer_abort_out) else $error("abort stuck");
    seq_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR)
        |=> state_reg.seq == $past(reg_wdata_in[dsc_pkg::SEQ_ABORT_BIT:0])) else $error("control bits lost");
    seq_read_a: assert property (
        reg_rd_in && hit(reg_addr_in, dsc_pkg::SEQ_CTRL_ADDR)
        |=> reg_rdata_out[dsc_pkg::SEQ_ABORT_BIT:0] == $past(state_reg.seq)) else $error("control read wrong");
    ptr_write_a: assert property (
        reg_wr_in && hit(reg_addr_in, dsc_pkg::PTR_ADDR)
        |=> state_reg.ptr == $past(reg_wdata_in[AW-1:0])) else $error("pointer not written");
    ptr_hold_a: assert property (
        rd_word |=> state_reg.ptr == $past(state_reg.ptr)) else $error("pointer moved on read");
    // Read data hold between answers
    rdata_hold_a: assert property (
        !reg_rvalid_out |-> $stable(reg_rdata_out)) else $error("read data changed");

    run_stop_c: cover property (reg_wr_in && hit(reg_addr_in, dsc_pkg::RUN_CTRL_ADDR) && channel_run_out != 4'h0);
    word_burst_c: cover property (wr_word ##1 wr_word);
    abort_c: cover property ($rose(sequencer_abort_out));
    status_fail_c: cover property (state_reg.factory_fail && state_reg.user_fail);
    word_read_c: cover property (rd_word ##2 reg_rvalid_out);
endmodule

// file: dsc_pkg.sv
package dsc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RUN_CTRL_ADDR = 8'h21;
    localparam logic [7:0] STATUS_ADDR = 8'h22;
    localparam logic [7:0] IFACE_ADDR = 8'h26;
    localparam logic [7:0] SEQ_CTRL_ADDR = 8'h27;
    localparam logic [7:0] PTR_ADDR = 8'h2b;
    localparam logic [7:0] WORD_ADDR = 8'h2c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int NUM_CH = 4;
    localparam int RUN_STRIDE = 4;
    localparam int ST_FACTORY_BIT = 15;
    localparam int ST_USER_BIT = 14;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_PART_LSB = 2;
    localparam int ST_PART_W = 6;
    localparam int ST_REV_W = 2;
    localparam int IF_TIMEOUT_BIT = 12;
    localparam int IF_QUICK_BIT = 2;
    localparam int IF_READBACK_BIT = 0;
    localparam int SEQ_ABORT_BIT = 2;
    localparam int SEQ_RUN_BIT = 1;
    localparam int SEQ_EN_BIT = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RUN_CTRL_RST = 16'h0000;
    localparam logic [15:0] IFACE_RST = 16'h0000;
    localparam logic [2:0] SEQ_CTRL_RST = 3'h3;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] PTR_STEP = 8'h01;
endpackage

// file: dsc_mem_if.sv
`timescale 1ns/1ps
interface dsc_mem_if #(parameter int AW = 8, parameter int DW = 16);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: dsc_param_mem.sv
`timescale 1ns/1ps
module dsc_param_mem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // Clock
    input wire logic mclk_in,
    // Port
    dsc_mem_if.mem port
);
    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rdata_reg;

    // Registered read; no reset so it maps onto block RAM
    always_ff @(posedge mclk_in) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        rdata_reg <= store[port.addr];
    end

    assign port.rdata = rdata_reg;
endmodule

// file: dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model (
    // Clock
    input wire logic mclk_in,
    // Register bus towards the device
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rvalid_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 16'h0000;
    end
    // reserved bits zero
    // Idle bus shows inverted values so stale data never passes
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_in);
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(negedge mclk_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(negedge mclk_in);
        reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(negedge mclk_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = 16'hxxxx;
        for (n = 0; n < 4; n++) begin
            if (reg_rvalid_in === 1'b1) begin
                d = reg_rdata_in;
                break;
            end
            @(negedge mclk_in);
        end
    endtask
endmodule

// file: dsc_regs_bench.sv
`timescale 1ns/1ps
module dsc_regs_bench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr, rd, rv, act, abt, qk, rb, tmo;
    logic [7:0] ad;
    logic [15:0] wd, rdat;
    logic [3:0] run_set = 4'h0;
    logic [3:0] run;
    logic fac = 1'b0;
    logic usr = 1'b0;
    logic busy = 1'b0;
    logic srst = 1'b0;
    int fails = 0;
    int comparisons = 0;
    always #2.5 mclk_in = ~mclk_in;
    dsc_host_model i_dsc_host_model (.mclk_in(mclk_in), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(ad),
        .reg_wdata_out(wd), .reg_rdata_in(rdat), .reg_rvalid_in(rv));
    dsc_regs #(.PART_ID(6'h2a), .REV_ID(2'h1)) i_dsc_regs (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdat),
        .reg_rvalid_out(rv), .run_set_in(run_set), .factory_load_check_fail_in(fac),
        .user_load_check_fail_in(usr), .nonvolatile_busy_in(busy), .soft_reset_in(srst),
        .channel_run_out(run), .sequencer_active_out(act), .sequencer_abort_out(abt),
        .quick_readback_enable_out(qk), .readback_output_enable_out(rb), .bus_timeout_enable_out(tmo));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        i_dsc_host_model.read_reg(a, d);
        check($sformatf("reg %h", a), e, d & m);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        i_dsc_host_model.write_reg(a, d);
        @(negedge mclk_in);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_test();
        rdc(dsc_pkg::RUN_CTRL_ADDR, 16'hffff, 16'h0000);
        rdc(dsc_pkg::STATUS_ADDR, 16'hffff, 16'h00a9);
        rdc(dsc_pkg::IFACE_ADDR, 16'h1005, 16'h0000);
        rdc(dsc_pkg::SEQ_CTRL_ADDR, 16'hffff, 16'h0003);
        rdc(dsc_pkg::PTR_ADDR, 16'h00ff, 16'h0000);
        check("active abort", 16'h0002, {14'h0, act, abt});
    endtask
    task automatic run_test();
        run_set = 4'hf;
        @(negedge mclk_in);
        run_set = 4'h0;
        @(negedge mclk_in);
        rdc(dsc_pkg::RUN_CTRL_ADDR, 16'hffff, 16'h1111);
        // Sequencer set wins over a host stop in the same cycle
        run_set = 4'h2;
        wr_reg(dsc_pkg::RUN_CTRL_ADDR, 16'h0000);
        run_set = 4'h0;
        check("run", 16'h0002, {12'h0, run});
        wr_reg(dsc_pkg::RUN_CTRL_ADDR, 16'h0000);
        rdc(dsc_pkg::RUN_CTRL_ADDR, 16'hffff, 16'h0000);
        check("run", 16'h0000, {12'h0, run});
    endtask
    task automatic status_test();
        {fac, usr, busy} = 3'b111;
        @(negedge mclk_in);
        {fac, usr} = 2'b00;
        @(negedge mclk_in);
        rdc(dsc_pkg::STATUS_ADDR, 16'hc100, 16'hc100);
        srst = 1'b1;
        @(negedge mclk_in);
        srst = 1'b0;
        @(negedge mclk_in);
        rdc(dsc_pkg::STATUS_ADDR, 16'hc100, 16'h0100);
        busy = 1'b0;
        repeat (2) @(negedge mclk_in);
        rdc(dsc_pkg::STATUS_ADDR, 16'hc100, 16'h0000);
    endtask
    task automatic iface_test();
        wr_reg(dsc_pkg::IFACE_ADDR, 16'h1005);
        rdc(dsc_pkg::IFACE_ADDR, 16'h1005, 16'h1005);
        check("iface out", 16'h0007, {13'h0, tmo, qk, rb});
        wr_reg(dsc_pkg::IFACE_ADDR, 16'h0004);
        check("iface out", 16'h0002, {13'h0, tmo, qk, rb});
        wr_reg(dsc_pkg::IFACE_ADDR, 16'h1001);
        check("iface out", 16'h0005, {13'h0, tmo, qk, rb});
    endtask
    task automatic seq_test();
        logic [2:0] w [5] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h7};
        logic [1:0] e [5] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01};
        for (int i = 0; i < 5; i++) begin
            wr_reg(dsc_pkg::SEQ_CTRL_ADDR, {13'h0, w[i]});
            check("active abort", {14'h0, e[i]}, {14'h0, act, abt});
        end
        rdc(dsc_pkg::SEQ_CTRL_ADDR, 16'hffff, 16'h0007);
        wr_reg(dsc_pkg::SEQ_CTRL_ADDR, 16'h0003);
    endtask
    // Word writes one idle cycle apart, read without increment, pointer wrap
    task automatic mem_test();
        wr_reg(dsc_pkg::PTR_ADDR, 16'h0010);
        i_dsc_host_model.write_reg(dsc_pkg::WORD_ADDR, 16'habcd);
        i_dsc_host_model.write_reg(dsc_pkg::WORD_ADDR, 16'h1234);
        rdc(dsc_pkg::PTR_ADDR, 16'h00ff, 16'h0012);
        wr_reg(dsc_pkg::PTR_ADDR, 16'h0010);
        rdc(dsc_pkg::WORD_ADDR, 16'hffff, 16'habcd);
        rdc(dsc_pkg::PTR_ADDR, 16'h00ff, 16'h0010);
        wr_reg(dsc_pkg::PTR_ADDR, 16'h0011);
        rdc(dsc_pkg::WORD_ADDR, 16'hffff, 16'h1234);
        wr_reg(dsc_pkg::PTR_ADDR, 16'h00ff);
        wr_reg(dsc_pkg::WORD_ADDR, 16'h5a5a);
        rdc(dsc_pkg::PTR_ADDR, 16'h00ff, 16'h0000);
        wr_reg(dsc_pkg::PTR_ADDR, 16'h00ff);
        rdc(dsc_pkg::WORD_ADDR, 16'hffff, 16'h5a5a);
    endtask
    task automatic unmapped_test();
        wr_reg(8'h30, 16'h1234);
        rdc(8'h30, 16'hffff, 16'h0000);
    endtask
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge mclk_in);
        rstn_in = 1'b1;
        reset_test();
        run_test();
        status_test();
        iface_test();
        seq_test();
        mem_test();
        unmapped_test();
        complete_run();
    end
endmodule
